// File: ssq_pkg.sv
// ssq_pkg: shared constants and types of the sweep sequencer.
// assumes one 10 MHz clock and the plain register port of ssq_sequencer.
`default_nettype none

package ssq_pkg;

    // =========================================================
    // register map (byte addresses on the 6-bit register port)
    localparam logic [5:0]  REG_CTRL     = 6'h00;
    localparam logic [5:0]  REG_STATUS   = 6'h04;
    localparam logic [5:0]  REG_RESULT0  = 6'h20;

    // =========================================================
    // control register fields
    localparam int          CTRL_START_BIT = 0;
    localparam int          CTRL_RES10_BIT = 1;
    localparam int          CTRL_DIV_LSB   = 2;
    localparam int          CTRL_GRP_LSB   = 4;
    localparam logic [5:0]  CTRL_RESET     = 6'h00;

    // status register fields
    localparam int          STAT_INT_BIT   = 0;
    localparam int          STAT_CHAN_LSB  = 1;
    localparam int          STAT_BUSY_BIT  = 4;

    // =========================================================
    // conversion clock selection and divider limits
    localparam logic [1:0]  DIV_SEL_BY4   = 2'h0;
    localparam logic [1:0]  DIV_SEL_BY2   = 2'h1;
    localparam logic [1:0]  DIV_LIMIT_BY4 = 2'h3;
    localparam logic [1:0]  DIV_LIMIT_BY2 = 2'h1;
    localparam logic [1:0]  DIV_LIMIT_BY1 = 2'h0;

    // =========================================================
    // successive approximation
    localparam logic [9:0]  SAR_INIT     = 10'h200;
    localparam logic [9:0]  SAR_RESET    = 10'h000;
    localparam logic [3:0]  BIT_FIRST    = 4'h9;
    localparam logic [3:0]  BIT_LAST_10  = 4'h0;
    localparam logic [3:0]  BIT_LAST_8   = 4'h2;
    // conversion ticks per sample or bit step, minus one
    localparam logic [1:0]  STEP_LAST    = 2'h3;
    localparam logic [2:0]  CHAN_LAST    = 3'h7;
    localparam logic [2:0]  CHAN_FIRST   = 3'h0;

    // analog side: channel mux, ladder code, sample switch
    typedef struct packed {
        logic [2:0] chan;
        logic [9:0] code;
        logic       sample;
    } ssq_analog_type;

    typedef enum logic [3:0] {
        ST_IDLE    = 4'b0001,
        ST_SAMPLE  = 4'b0010,
        ST_COMPARE = 4'b0100,
        ST_STORE   = 4'b1000
    } ssq_state_type;

endpackage : ssq_pkg

`default_nettype wire

// File: ssq_clk_div.sv
// ssq_clk_div: conversion clock enable, source clock /4, /2 or /1.
// assumes the selection only changes while conversion is stopped.
`timescale 1ns/1ps
`default_nettype none

module ssq_clk_div
    import ssq_pkg::*;
(
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_n,
    input  wire logic [1:0] i_sel,
    output logic            o_tick
);

    logic [1:0] cnt;
    logic [1:0] next_cnt;
    logic [1:0] limit;
    logic       next_tick;

    // =========================================================
    // divider
    // [R8] divided clock select
    always_comb begin
        unique case (i_sel)
            DIV_SEL_BY4: limit = DIV_LIMIT_BY4;
            DIV_SEL_BY2: limit = DIV_LIMIT_BY2;
            default:     limit = DIV_LIMIT_BY1;
        endcase
        next_tick = (cnt >= limit);
        next_cnt  = next_tick ? 2'h0 : cnt + 2'h1;
    end

    // tick is a one-cycle enable, registered so it is glitch free
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt    <= 2'h0;
            o_tick <= 1'b0;
        end else begin
            cnt    <= next_cnt;
            o_tick <= next_tick;
        end
    end

    // =========================================================
    // checks
    // the selection must hold over the whole spacing; a change while
    // stopped may legally shorten one gap
    AST_DIV_BY4: assert property ( // [R8]
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (o_tick && i_sel == DIV_SEL_BY4 && $stable(i_sel))
            ##1 (i_sel == DIV_SEL_BY4) [*4]
            |-> o_tick && !$past(o_tick, 1) && !$past(o_tick, 2)
                && !$past(o_tick, 3))
        else $error("divide by four spacing wrong");

endmodule // ssq_clk_div

`default_nettype wire

// File: ssq_sequencer.sv
// ssq_sequencer: repeat sweep 1 control of a 10-bit SAR converter.
// assumes a comparator and reference ladder outside; its compare input
// is asynchronous and is synchronised here.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// [R1] a start flag set to one begins with channel zero
// [R2] channel zero result goes to result register zero
// [R3] after the selected group, one unselected channel, then back to zero
// [R4] software picks group: channel 0, 0-1, 0-2 or 0-3
// [R5] every finished conversion lands in its own channel's register
// [R6] the interrupt request never rises in this mode
// [R7] sweeping runs until software writes start flag zero
// [R8] conversion clock is source divided by four, two, or one
// [R9] software changes configuration only while stopped
// [R10] software waits one microsecond after enabling reference
// [R11] software sets analog and trigger pins as inputs
// [R12] with key interrupts, channels four to seven unused
// [R13] at low supply use divided clock, no hold, 8-bit
// [R14] software rewrites channel bits after any mode change
// [R15] in one-shot modes software checks completion before reading
// [R16] repeat modes need the undivided main clock for the CPU
// [R17] conversion clock stays below 10 MHz; divide by one here runs it at the full 10 MHz source clock
// [R18] register starts at 1000000000, bit nine kept if reference lower
// [R19] bits eight to zero: set, compare, keep if reference lower
// [R20] result copied only after the last bit is resolved
// [R21] ladder voltage follows the current register code
// [R22] 8-bit mode stores upper eight bits in bits zero to seven
// [R23] inserted unselected channels ascend and wrap to the first
module ssq_sequencer
    import ssq_pkg::*;
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_n,
    input  wire logic [5:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    input  wire logic        i_cmp_lower,
    output ssq_analog_type   o_analog,
    output logic             o_int_req
);

    // =========================================================
    // functions
    // stored value: full code, or upper eight bits right aligned
    function automatic logic [9:0] result_of(input logic [9:0] sar,
                                             input logic       res10);
        result_of = res10 ? sar : {2'b00, sar[9:2]};
    endfunction

    // lowest channel outside the selected group
    function automatic logic [2:0] first_unsel(input logic [1:0] grp);
        first_unsel = {1'b0, grp} + 3'h1;
    endfunction

    // =========================================================
    // declarations
    logic [5:0]      ctrl;
    logic [5:0]      next_ctrl;
    logic [31:0]     next_rdata;
    logic            cmp_meta;
    logic            cmp_sync;
    logic            tick;
    ssq_state_type   state;
    ssq_state_type   next_state;
    logic [9:0]      sar;
    logic [9:0]      next_sar;
    logic [3:0]      bit_idx;
    logic [3:0]      next_bit;
    logic [3:0]      lower_bit;
    logic [3:0]      last_bit;
    logic [1:0]      step;
    logic [1:0]      next_step;
    logic [2:0]      chan;
    logic [2:0]      next_chan;
    logic [2:0]      uns_ptr;
    logic [2:0]      next_uns;
    logic            store;
    logic [9:0]      store_data;
    logic [9:0]      results [0:7];
    logic            start;
    logic            res10;
    logic [1:0]      grp;
    logic [2:0]      grp_last;

    assign start    = ctrl[CTRL_START_BIT];
    assign res10    = ctrl[CTRL_RES10_BIT];
    assign grp      = ctrl[CTRL_GRP_LSB +: 2];
    assign grp_last = {1'b0, grp};

    // =========================================================
    // conversion clock enable
    ssq_clk_div u_div (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_sel     (ctrl[CTRL_DIV_LSB +: 2]),
        .o_tick    (tick)
    );

    // =========================================================
    // comparator synchroniser; only the second stage is read
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cmp_meta <= 1'b0;
            cmp_sync <= 1'b0;
        end else begin
            cmp_meta <= i_cmp_lower;
            cmp_sync <= cmp_meta;
        end
    end

    // =========================================================
    // register port: next control value and read data
    always_comb begin
        next_ctrl  = ctrl;
        next_rdata = 32'h0000_0000;
        if (i_wr && i_addr == REG_CTRL) begin
            next_ctrl = i_wdata[5:0];
        end
        if (i_rd) begin
            if (i_addr == REG_CTRL) begin
                next_rdata[5:0] = ctrl;
            end else if (i_addr == REG_STATUS) begin
                next_rdata[STAT_INT_BIT]        = o_int_req;
                next_rdata[STAT_CHAN_LSB +: 3]  = chan;
                next_rdata[STAT_BUSY_BIT]       = (state != ST_IDLE);
            end else if (i_addr[5] && i_addr[1:0] == 2'b00) begin
                next_rdata[9:0] = results[i_addr[4:2]];
            end
        end
    end

    // read data stand for one cycle only, zero otherwise
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl    <= CTRL_RESET;
            o_rdata <= 32'h0000_0000;
        end else begin
            ctrl    <= next_ctrl;
            o_rdata <= next_rdata;
        end
    end

    // =========================================================
    // conversion sequencer
    always_comb begin
        next_state = state;
        next_sar   = sar;
        next_bit   = bit_idx;
        next_step  = step;
        next_chan  = chan;
        next_uns   = uns_ptr;
        store      = 1'b0;
        lower_bit  = bit_idx - 4'h1;
        last_bit   = res10 ? BIT_LAST_10 : BIT_LAST_8;
        store_data = result_of(sar, res10);
        if (!start) begin
            // [R7] stop on clear
            next_state = ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    // [R1] begin at channel zero
                    next_state = ST_SAMPLE;
                    next_chan  = CHAN_FIRST;
                    next_step  = 2'h0;
                    next_uns   = first_unsel(grp);
                end
                ST_SAMPLE: begin
                    if (tick) begin
                        next_step = step + 2'h1;
                        if (step == STEP_LAST) begin
                            // [R18] start code preset
                            next_sar   = SAR_INIT;
                            next_bit   = BIT_FIRST;
                            next_state = ST_COMPARE;
                        end
                    end
                end
                ST_COMPARE: begin
                    // step time covers the synchroniser delay
                    if (tick) begin
                        next_step = step + 2'h1;
                        if (step == STEP_LAST) begin
                            // [R19] keep bit if reference lower
                            if (!cmp_sync) begin
                                next_sar[bit_idx] = 1'b0;
                            end
                            if (bit_idx == last_bit) begin
                                next_state = ST_STORE;
                            end else begin
                                next_bit            = lower_bit;
                                next_sar[lower_bit] = 1'b1;
                            end
                        end
                    end
                end
                ST_STORE: begin
                    // [R20] copy after last bit
                    store      = 1'b1;
                    next_state = ST_SAMPLE;
                    next_step  = 2'h0;
                    // [R3] interleave one unselected
                    if (chan == grp_last) begin
                        next_chan = uns_ptr;
                    end else if (chan < grp_last) begin
                        next_chan = chan + 3'h1;
                    end else begin
                        next_chan = CHAN_FIRST;
                        // [R23] ascend and wrap
                        if (uns_ptr == CHAN_LAST) begin
                            next_uns = first_unsel(grp);
                        end else begin
                            next_uns = uns_ptr + 3'h1;
                        end
                    end
                end
            endcase
        end
    end

    // sequencer state, results and analog outputs
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state     <= ST_IDLE;
            sar       <= SAR_RESET;
            bit_idx   <= BIT_FIRST;
            step      <= 2'h0;
            chan      <= CHAN_FIRST;
            uns_ptr   <= CHAN_LAST;
            o_analog  <= '0;
            o_int_req <= 1'b0;
            for (int i = 0; i < 8; i++) begin
                results[i] <= SAR_RESET;
            end
        end else begin
            state   <= next_state;
            sar     <= next_sar;
            bit_idx <= next_bit;
            step    <= next_step;
            chan    <= next_chan;
            uns_ptr <= next_uns;
            // [R2] [R5] [R22] per-channel result
            if (store) begin
                results[chan] <= store_data;
            end
            // [R21] ladder follows code
            o_analog.chan   <= next_chan;
            o_analog.code   <= next_sar;
            o_analog.sample <= (next_state == ST_SAMPLE);
            // [R6] no interrupt in this mode
            o_int_req <= 1'b0;
        end
    end

    // =========================================================
    // checks
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);

    AST_START_CH0: assert property ( // [R1]
        (state == ST_IDLE && start) |=> (state == ST_SAMPLE && chan == 3'h0))
        else $error("sweep did not start at channel zero");

    AST_RESULT0: assert property ( // [R2]
        (store && chan == 3'h0) |=> results[0] == $past(store_data))
        else $error("channel zero result not stored");

    AST_UNSEL_AFTER: assert property ( // [R3]
        (store && chan == grp_last && start) |=> chan > grp_last)
        else $error("no unselected channel after group");

    AST_BACK_TO_ZERO: assert property ( // [R3]
        (store && chan > grp_last && start) |=> chan == 3'h0)
        else $error("sweep did not return to channel zero");

    AST_RESULT_I: assert property ( // [R5]
        store |=> results[$past(chan)] == $past(store_data))
        else $error("result landed in wrong register");

    AST_NO_IRQ: assert property ( // [R6]
        !o_int_req)
        else $error("interrupt request raised");

    AST_STOP: assert property ( // [R7]
        $fell(start) |=> state == ST_IDLE && !o_analog.sample)
        else $error("converter kept running after stop");

    AST_SAR_INIT: assert property ( // [R18]
        (state == ST_SAMPLE && next_state == ST_COMPARE)
            |=> sar == 10'h200 && o_analog.code == 10'h200)
        else $error("approximation did not start at midscale");

    AST_BIT_TRIAL: assert property ( // [R19]
        (state == ST_COMPARE && $changed(bit_idx))
            |-> sar[bit_idx] && (sar & ((10'h001 << bit_idx) - 10'h001))
                == 10'h000)
        else $error("trial bit not set or lower bits dirty");

    AST_STORE_LAST: assert property ( // [R20]
        (state == ST_COMPARE && next_state == ST_STORE) |-> bit_idx == last_bit)
        else $error("result stored before last bit");

    AST_EIGHT_BIT: assert property ( // [R22]
        (store && !res10) |=> results[$past(chan)][9:8] == 2'b00)
        else $error("8-bit result not right aligned");

    AST_UNSEL_WRAP: assert property ( // [R23]
        (store && chan > grp_last && uns_ptr == 3'h7 && start)
            |=> uns_ptr == first_unsel(grp))
        else $error("unselected pointer did not wrap");

    AST_CHAN_HOLD: assert property ( // [R5]
        (state == ST_COMPARE) |=> $stable(o_analog.chan))
        else $error("mux channel moved during a conversion");

    AST_LADDER_CODE: assert property ( // [R21]
        o_analog.code == sar)
        else $error("ladder code differs from approximation");

    AST_EIGHT_LAST: assert property ( // [R22]
        (state == ST_COMPARE && !res10) |-> bit_idx >= BIT_LAST_8)
        else $error("8-bit conversion resolved too many bits");

    AST_UNSEL_PTR: assert property ( // [R23]
        (state == ST_COMPARE && chan > grp_last) |-> chan == uns_ptr)
        else $error("unselected channel is not the pointer");

    AST_IDLE_QUIET: assert property ( // [R7]
        (state == ST_IDLE && !start)
            |=> state == ST_IDLE && !o_analog.sample)
        else $error("converter woke up without the start flag");

endmodule // ssq_sequencer

`default_nettype wire

// File: ssq_analog_model.sv
// ssq_analog_model: comparator and reference ladder beside ssq_sequencer.
// assumes i_vin holds eight input levels, 11 bits each, in vref/2048 steps.
`timescale 1ns/1ps
`default_nettype none

module ssq_analog_model
    import ssq_pkg::*;
(
    input  wire logic           i_ref_clk,
    input  wire logic [87:0]    i_vin,
    input  wire ssq_analog_type i_analog,
    output logic                o_cmp_lower
);
    // =========================================================
    // ladder and comparator
    logic [11:0] ladder;
    logic [10:0] vin_sel;
    logic        junk = 1'b0;

    // levels are pure inputs; no key interrupt is modelled
    assign ladder = (i_analog.code == 10'h000) ? 12'h000
                  : {1'b0, i_analog.code, 1'b0} - 12'h001;
    assign vin_sel = i_vin[i_analog.chan * 11 +: 11];

    // while sampling the comparator means nothing, so it wanders
    always_ff @(posedge i_ref_clk) begin
        junk <= ~junk;
    end

    assign o_cmp_lower = i_analog.sample ? junk
                       : (ladder < {1'b0, vin_sel});
endmodule // ssq_analog_model

`default_nettype wire

// File: sar_adc_sweep_sequencer_tb.sv
// sar_adc_sweep_sequencer_tb: self-checking bench for ssq_sequencer.
// assumes ssq_analog_model stands in for the mux, ladder and comparator.
`timescale 1ns/1ps
`default_nettype none

module sar_adc_sweep_sequencer_tb
    import ssq_pkg::*;
();
    logic           i_ref_clk = 1'b0;
    logic           i_rst_n   = 1'b0;
    logic [5:0]     i_addr    = 6'h00;
    logic [31:0]    i_wdata   = 32'h0000_0000;
    logic           i_wr      = 1'b0;
    logic           i_rd      = 1'b0;
    logic [31:0]    o_rdata;
    logic           cmp_lower;
    ssq_analog_type analog;
    logic           o_int_req;
    logic [87:0]    sampled_input_voltage;
    logic [9:0]     lvl [8] = '{10'h2a5, 10'h13c, 10'h3ff, 10'h001,
                                10'h200, 10'h0aa, 10'h355, 10'h1e1};
    logic [2:0]     chq [$];
    logic           samp_q     = 1'b0;
    int             int_seen   = 0;
    int             n_mismatch = 0;
    int             num_checks = 0;

    // =========================================================
    // design, partner and clock
    ssq_sequencer dut (
        .i_ref_clk   (i_ref_clk),
        .i_rst_n     (i_rst_n),
        .i_addr      (i_addr),
        .i_wdata     (i_wdata),
        .i_wr        (i_wr),
        .i_rd        (i_rd),
        .o_rdata     (o_rdata),
        .i_cmp_lower (cmp_lower),
        .o_analog    (analog),
        .o_int_req   (o_int_req)
    );
    ssq_analog_model partner (
        .i_ref_clk   (i_ref_clk),
        .i_vin       (sampled_input_voltage),
        .i_analog    (analog),
        .o_cmp_lower (cmp_lower)
    );
    initial begin
        forever #50 i_ref_clk = ~i_ref_clk;
    end

    // log each conversion's channel; negedge avoids racing the design
    always @(negedge i_ref_clk) begin
        samp_q <= analog.sample;
        if (analog.sample === 1'b1 && samp_q === 1'b0) begin
            chq.push_back(analog.chan);
        end
        if (o_int_req !== 1'b0) begin
            int_seen <= int_seen + 1;
        end
    end

    // =========================================================
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic reg_wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_ref_clk);
        i_wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [5:0] a, output logic [31:0] d);
        @(posedge i_ref_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd   <= 1'b0;
        #1 d = o_rdata;
    endtask

    function automatic logic [31:0] ctrl(input logic [1:0] g,
                                         input logic [1:0] d, input logic r);
        return (32'(g) << CTRL_GRP_LSB) | (32'(d) << CTRL_DIV_LSB)
             | (32'(r) << CTRL_RES10_BIT);
    endfunction

    task automatic go(input logic [31:0] cfg);
        chq.delete();
        reg_wr(REG_CTRL, cfg);
        // settle a microsecond before the start
        repeat (10) @(posedge i_ref_clk);
        reg_wr(REG_CTRL, cfg | (32'h1 << CTRL_START_BIT));
    endtask

    task automatic stop(input logic [31:0] cfg);
        int          q;
        logic [31:0] d;
        reg_wr(REG_CTRL, cfg);
        // a conversion may still be logged from the write edge itself
        repeat (2) @(posedge i_ref_clk);
        q = chq.size();
        repeat (200) @(posedge i_ref_clk);
        check(32'(chq.size()), 32'(q));
        reg_rd(REG_STATUS, d);
        check(d & 32'h0000_0011, 32'h0);
        check(32'(int_seen), 32'h0);
    endtask

    task automatic wait_conv(input int n);
        int k;
        k = 0;
        while (chq.size() < n && k < 8000) begin
            @(posedge i_ref_clk);
            k++;
        end
        if (chq.size() < n) check(32'(chq.size()), 32'(n));
    endtask

    // cycles until the ladder code next changes
    task automatic wait_code(output int n);
        logic [9:0] p;
        @(negedge i_ref_clk);
        p = analog.code;
        n = 1;
        while (analog.code === p && n < 200) begin
            @(negedge i_ref_clk);
            n++;
        end
    endtask

    task automatic check_seq(input int g, input int n);
        int         u;
        logic [2:0] e [$];
        u = g + 1;
        while (e.size() < n) begin
            for (int i = 0; i <= g; i++) e.push_back(3'(i));
            e.push_back(3'(u));
            u = (u == 7) ? g + 1 : u + 1;
        end
        for (int i = 0; i < n; i++) begin
            check(32'(chq[i]), 32'(e[i]));
        end
    endtask

    task automatic check_results(input logic res10);
        logic [31:0] d;
        for (int i = 0; i < 8; i++) begin
            reg_rd(REG_RESULT0 + 6'(4 * i), d);
            check(d, res10 ? 32'(lvl[i]) : 32'(lvl[i][9:2]));
        end
    endtask

    // =========================================================
    // scenarios
    // full supply, repeat sweep only, no cpu clock
    task automatic t_reset();
        logic [31:0] d;
        @(negedge i_ref_clk);
        check(32'(analog), 32'h0);
        reg_rd(REG_STATUS, d);
        check(d, 32'h0);
        reg_rd(REG_RESULT0, d);
        check(d, 32'h0);
        reg_rd(6'h3c, d);
        check(d, 32'h0);
        $display("test reset done");
    endtask

    // single-channel group, first trial codes, then a full wrap
    task automatic t_first_sweep();
        logic [31:0] d;
        int          n;
        go(ctrl(2'h0, 2'h2, 1'b1));
        wait_conv(1);
        check(32'(chq[0]), 32'h0);
        wait_code(n);
        check(32'(analog.code), 32'h200);
        wait_code(n);
        check(32'(analog.code), 32'h300);
        reg_rd(REG_RESULT0, d);
        check(d, 32'h0);
        reg_rd(REG_STATUS, d);
        check(d, 32'h0000_0010);
        wait_conv(16);
        check_seq(0, 16);
        stop(ctrl(2'h0, 2'h2, 1'b1));
        check_results(1'b1);
        $display("test first sweep done");
    endtask

    task automatic t_group3_8bit();
        logic [31:0] d;
        go(ctrl(2'h3, 2'h2, 1'b0));
        reg_rd(REG_CTRL, d);
        check(d, ctrl(2'h3, 2'h2, 1'b0) | 32'h0000_0001);
        wait_conv(26);
        check_seq(3, 26);
        stop(ctrl(2'h3, 2'h2, 1'b0));
        check_results(1'b0);
        $display("test group three done");
    endtask

    // middle group sizes, 10-bit, undivided
    task automatic t_groups();
        for (int g = 1; g < 3; g++) begin
            go(ctrl(2'(g), 2'h2, 1'b1));
            wait_conv(12);
            check_seq(g, 12);
            stop(ctrl(2'(g), 2'h2, 1'b1));
        end
        $display("test groups one and two done");
    endtask

    // bit steps last four conversion ticks
    task automatic t_divider();
        int exp [4] = '{16, 8, 4, 4};
        int n;
        for (int s = 0; s < 4; s++) begin
            go(ctrl(2'h0, 2'(s), 1'b1));
            repeat (4) wait_code(n);
            check(32'(n), 32'(exp[s]));
            stop(ctrl(2'h0, 2'(s), 1'b1));
        end
        $display("test divider done");
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // =========================================================
    // main sequence and watchdog
    initial begin
        for (int i = 0; i < 8; i++) sampled_input_voltage[i * 11 +: 11] = {lvl[i], 1'b0};
        repeat (2) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        t_reset();
        t_first_sweep();
        t_group3_8bit();
        t_groups();
        t_divider();
        end_of_test();
    end

    // the run needs well under 8000 cycles; 20000 means a hang
    initial begin
        #2_000_000;
        n_mismatch++;
        end_of_test();
    end
endmodule // sar_adc_sweep_sequencer_tb

`default_nettype wire
